/* core/encoder_emulator.v */
`include "servo_defs.vh"
module encoder_emulator (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Shaft angle and settings
    input wire [15:0] angle,
    input wire [14:0] res,
    input wire [1:0] div_sel,
    input wire [15:0] max_speed,
    input wire [11:0] dband,
    input wire [14:0] zshift,
    // Emulated channels
    output reg a_q,
    output reg b_q,
    output reg z_q
);
    reg [15:0] held_q;
    reg [16:0] cnt_q;
    reg [16:0] cnt_d;
    reg [14:0] res_max;
    reg [14:0] res_ok;

    always @* begin
        if (max_speed <= 16'd1600) res_max = 15'h4000;
        else if (max_speed <= 16'd3200) res_max = 15'h2000;
        else if (max_speed <= 16'd6400) res_max = 15'h1000;
        else if (max_speed <= 16'd12800) res_max = 15'h0800;
        else res_max = 15'h0400;
        res_ok = (res < `RES_MIN) ? `RES_MIN : ((res > res_max) ? res_max : res);
    end

    wire [14:0] res_eff = res_ok >> div_sel;
    wire [16:0] res4 = {res_eff, 2'b00};
    wire [15:0] adiff = angle - held_q;
    wire [15:0] amag = adiff[15] ? (~adiff + 16'h0001) : adiff;
    wire [32:0] tprod = held_q * res4;
    wire [16:0] target = tprod[32:16];
    // Shift of 32767 spans a whole turn; one count is a quarter period
    wire [31:0] zprod = zshift * res4;
    wire [16:0] zcnt = zprod[31:15];
    wire [16:0] up_d = target - cnt_q;
    wire [16:0] dn_d = cnt_q - target;
    wire fwd = up_d <= {1'b0, res4[16:1]};

    always @* begin
        cnt_d = cnt_q;
        if (target != cnt_q) begin
            if (fwd) cnt_d = (cnt_q >= res4 - 17'h00001) ? 17'h00000 : cnt_q + 17'h00001;
            else cnt_d = (cnt_q == 17'h00000 || cnt_q >= res4) ? res4 - 17'h00001 : cnt_q - 17'h00001;
        end
        if (dn_d == 17'h00000) cnt_d = cnt_q;
    end

    always @(posedge clk) begin
        if (rst) begin
            held_q <= 16'h0000;
            cnt_q <= 17'h00000;
            a_q <= 1'b0;
            b_q <= 1'b0;
            z_q <= 1'b0;
        end else begin
            // Holding the angle hides +/-1 edge chatter at rest
            if (amag > {4'h0, dband}) held_q <= angle;
            cnt_q <= cnt_d;
            a_q <= cnt_d[1] ^ cnt_d[0];
            b_q <= cnt_d[1];
            z_q <= cnt_d == zcnt;
        end
    end
endmodule

/* core/i2t_limit.v */
`include "servo_defs.vh"
module i2t_limit (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Time base and current
    input wire tick,
    input wire [15:0] demand,
    input wire [7:0] rated,
    input wire [7:0] maxc,
    // Limit active
    output reg clamp_q
);
    reg [31:0] acc_q;
    wire [15:0] r2 = rated * rated;
    wire [15:0] m2 = maxc * maxc;
    // Peak allowed 4000·r² ms at max²/ms, i.e. 4·r²/m² seconds
    wire [31:0] budget = r2 * `PEAK_MS_FACTOR;
    wire over = demand > {1'b0, rated, 7'h00};

    always @(posedge clk) begin
        if (rst) begin
            acc_q <= 32'h0000_0000;
            clamp_q <= 1'b0;
        end else begin
            if (tick && over && acc_q < budget) begin
                acc_q <= acc_q + {16'h0000, m2};
            end else if (tick && !over) begin
                acc_q <= (acc_q > {16'h0000, r2}) ? acc_q - {16'h0000, r2} : 32'h0000_0000;
            end
            // Clamp to rated and keep running; no fault is raised
            clamp_q <= acc_q >= budget;
        end
    end
endmodule

/* core/servo_defs.vh */
// Notes on behaviour
// - Limiting mode clamps at rated, no fault
// - Peak time before clamp as fusing
// - Peak seconds equal four rated² over max²
// - Marker-to-marker count must equal resolution·pitch
// - Encoder frequency at 1.5 max flags error
// - Counting error disables power stage at once
// - Pitch 15: marker position must not drift
// - Absolute mode: position error above threshold faults
// - Model mode: error minus model above threshold
// - Limit switches block their own direction
// - Blocked direction brakes with maximum current
// - Speed mode zero command ramps to rest
// - Torque mode zero command holds current zero
// - Any fault disables the power stage
// - Faults open relay; undervoltage only if selected
// - Brake output only enabled and fault free
// - Emulated quadrature A/B plus one marker
// - Output resolution 512 up to speed band limit
// - Output resolution divided by 2, 4, 8
// - Standstill deadband, 4095 is 1/16 turn
// - Marker shift, 32767 is one turn
// - Marker width one quarter of A/B period
// - Analog limit: 0 V free, reversal inverts
`ifndef SERVO_DEFS_VH
`define SERVO_DEFS_VH
// ==========================================================
// Register offsets
`define ADDR_CTRL 8'h00
`define ADDR_CURRENT 8'h04
`define ADDR_ENC 8'h08
`define ADDR_MAX_SPEED 8'h0c
`define ADDR_FOLLOW_THR 8'h10
`define ADDR_OUT_RES 8'h14
`define ADDR_DEADBAND 8'h18
`define ADDR_ZSHIFT 8'h1c
`define ADDR_RAMP 8'h20
`define ADDR_STATUS 8'h24
`define ADDR_POSITION 8'h28
`define ADDR_EDGES 8'h2c
// ==========================================================
// Control fields
`define CTRL_FOLLOW_REL 0
`define CTRL_UV_RELAY 1
`define CTRL_ILIM_REV 2
`define CTRL_FAULT_CLR 3
`define CTRL_DIV_LO 4
`define CTRL_DIV_HI 5
// ==========================================================
// Reset values
`define RST_RATED 8'h10
`define RST_MAX 8'h20
`define RST_ENC_RES 16'h0400
`define RST_PITCH 4'h1
`define RST_MAX_SPEED 16'h0bb8
`define RST_FOLLOW_THR 24'h001000
`define RST_OUT_RES 15'h0400
`define RST_RAMP 16'h0010
// ==========================================================
// Fixed figures
`define PITCH_SINGLE_REF 4'hf
`define FREQ_SCALE 16'h2710
`define PEAK_MS_FACTOR 16'h0fa0
`define RES_MIN 15'h0200
`define CLK_NS 8
`define MS_NS 1000000
`define ZERO_CMD_RESP_NS 500000
`endif

/* core/servo_drive_protection_io.v */
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "servo_defs.vh"
module servo_drive_protection_io #(
    parameter MS_CYCLES = `MS_NS / `CLK_NS
) (
    // Clock and reset
    input wire CLK,
    input wire SYS_RST,
    // Register port
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR_STB,
    input wire RD_STB,
    output reg [31:0] RDATA,
    // Field pins
    input wire CW_LIMIT_SWITCH,
    input wire CCW_LIMIT_SWITCH,
    input wire TORQUE_MODE_SELECT,
    input wire ZERO_COMMAND_INPUT,
    input wire ENABLE_IN,
    input wire FAULT_RESET_IN,
    input wire UNDERVOLT_IN,
    input wire EXT_FAULT_IN,
    // Motor encoder pins
    input wire ENC_A,
    input wire ENC_B,
    input wire ENC_Z,
    // Servo loop values
    input wire [15:0] TORQUE_CMD,
    input wire [15:0] SPEED_CMD,
    input wire [15:0] SPEED_FB,
    input wire [23:0] POS_ERR,
    input wire [23:0] MODEL_ERR,
    input wire [11:0] ILIM_ADC,
    input wire [15:0] SHAFT_ANGLE,
    // Drive outputs
    output reg [15:0] CUR_REF,
    output reg [15:0] SPEED_REF,
    output reg PWR_EN,
    output reg DRIVE_OK_RELAY,
    output reg BRAKE_OUT,
    // Emulated encoder
    output wire EMU_A,
    output wire EMU_B,
    output wire EMU_Z
);
    localparam integer MS_LAST_I = MS_CYCLES - 1;
    localparam [16:0] MS_LAST = MS_LAST_I[16:0];

    function [23:0] mag24;
        input [23:0] v;
        begin
            mag24 = v[23] ? (~v + 24'h000001) : v;
        end
    endfunction

    function [31:0] mul16;
        input [15:0] x;
        input [15:0] y;
        begin
            mul16 = x * y;
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    reg [10:0] sync1_q;
    reg [10:0] sync2_q;
    always @(posedge CLK) begin
        if (SYS_RST) begin
            sync1_q <= 11'h000;
            sync2_q <= 11'h000;
        end else begin
            sync1_q <= {ENC_Z, ENC_B, ENC_A, EXT_FAULT_IN, UNDERVOLT_IN, FAULT_RESET_IN,
                        ENABLE_IN, ZERO_COMMAND_INPUT, TORQUE_MODE_SELECT,
                        CCW_LIMIT_SWITCH, CW_LIMIT_SWITCH};
            sync2_q <= sync1_q;
        end
    end
    wire cw_limit_switch = sync2_q[0];
    wire ccw_limit_switch = sync2_q[1];
    wire torque_mode_select = sync2_q[2];
    wire zero_command_input = sync2_q[3];
    wire enable = sync2_q[4];
    wire reset_pin = sync2_q[5];
    wire undervolt = sync2_q[6];
    wire ext_fault = sync2_q[7];
    wire [1:0] ab = sync2_q[9:8];
    wire z_mark = sync2_q[10];

    // ==========================================================
    // Millisecond time base
    reg [16:0] ms_cnt_q;
    wire ms_tick = ms_cnt_q == MS_LAST;
    always @(posedge CLK) begin
        if (SYS_RST || ms_tick) ms_cnt_q <= 17'h00000;
        else ms_cnt_q <= ms_cnt_q + 17'h00001;
    end

    // ==========================================================
    // Registers
    reg [5:0] ctrl_q;
    reg [7:0] rated_q;
    reg [7:0] maxc_q;
    reg [15:0] enc_res_q;
    reg [3:0] pitch_q;
    reg [15:0] max_speed_q;
    reg [23:0] thr_q;
    reg [14:0] out_res_q;
    reg [11:0] dband_q;
    reg [14:0] zshift_q;
    reg [15:0] ramp_q;
    wire wr_ctrl = WR_STB && ADDR == `ADDR_CTRL;
    wire clr_req = (wr_ctrl && WDATA[`CTRL_FAULT_CLR]) || reset_pin;

    always @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_q <= 6'h00;
            rated_q <= `RST_RATED;
            maxc_q <= `RST_MAX;
            enc_res_q <= `RST_ENC_RES;
            pitch_q <= `RST_PITCH;
            max_speed_q <= `RST_MAX_SPEED;
            thr_q <= `RST_FOLLOW_THR;
            out_res_q <= `RST_OUT_RES;
            dband_q <= 12'h000;
            zshift_q <= 15'h0000;
            ramp_q <= `RST_RAMP;
        end else if (WR_STB) begin
            case (ADDR)
                `ADDR_CTRL: ctrl_q <= {WDATA[5:4], 1'b0, WDATA[2:0]};
                `ADDR_CURRENT: begin
                    rated_q <= WDATA[7:0];
                    maxc_q <= WDATA[15:8];
                end
                `ADDR_ENC: begin
                    enc_res_q <= WDATA[15:0];
                    pitch_q <= WDATA[19:16];
                end
                `ADDR_MAX_SPEED: max_speed_q <= WDATA[15:0];
                `ADDR_FOLLOW_THR: thr_q <= WDATA[23:0];
                `ADDR_OUT_RES: out_res_q <= WDATA[14:0];
                `ADDR_DEADBAND: dband_q <= WDATA[11:0];
                `ADDR_ZSHIFT: zshift_q <= WDATA[14:0];
                `ADDR_RAMP: ramp_q <= WDATA[15:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // ==========================================================
    // Encoder counting supervision
    reg [1:0] ab_q;
    reg z_q;
    reg [23:0] pos_q;
    reg [23:0] zpos_q;
    reg armed_q;
    reg [15:0] edge_cnt_q;
    reg [15:0] edges_ms_q;
    wire ab_move = ab != ab_q;
    wire ab_jump = ab[0] != ab_q[0] && ab[1] != ab_q[1];
    wire count_up = ab[0] ^ ab_q[1];
    wire z_rise = z_mark && !z_q;
    wire [19:0] rev_pulses = enc_res_q * pitch_q;
    wire [23:0] exp_edges = {2'b00, rev_pulses, 2'b00};
    wire [23:0] z_span = mag24(pos_q - zpos_q);
    wire single_ref = pitch_q == `PITCH_SINGLE_REF;
    wire z_check = z_rise && armed_q && pitch_q != 4'h0;
    wire cnt_set = ab_jump || (z_check && !single_ref && z_span != exp_edges);
    wire ref_set = z_check && single_ref && pos_q != zpos_q;
    // Edges/ms ·10000 >= res·rpm is the 1.5x limit in quarter periods
    wire frq_set = ms_tick &&
        mul16(edge_cnt_q, `FREQ_SCALE) >= mul16(enc_res_q, max_speed_q);

    always @(posedge CLK) begin
        if (SYS_RST) begin
            ab_q <= 2'b00;
            z_q <= 1'b0;
            pos_q <= 24'h000000;
            zpos_q <= 24'h000000;
            armed_q <= 1'b0;
            edge_cnt_q <= 16'h0000;
            edges_ms_q <= 16'h0000;
        end else begin
            ab_q <= ab;
            z_q <= z_mark;
            if (ab_move && !ab_jump) pos_q <= count_up ? pos_q + 24'h000001 : pos_q - 24'h000001;
            if (ms_tick) begin
                edges_ms_q <= edge_cnt_q;
                edge_cnt_q <= {15'h0000, ab_move};
            end else if (ab_move && edge_cnt_q != 16'hffff) begin
                edge_cnt_q <= edge_cnt_q + 16'h0001;
            end
            // A fault reset clears armed_q so that a fresh marker is captured
            if (clr_req) armed_q <= 1'b0;
            else if (z_rise) armed_q <= 1'b1;
            if (z_rise && (!armed_q || !single_ref)) zpos_q <= pos_q;
        end
    end

    // ==========================================================
    // Following error
    wire [23:0] follow_err = ctrl_q[`CTRL_FOLLOW_REL] ?
        mag24(POS_ERR - MODEL_ERR) : mag24(POS_ERR);
    wire fol_set = enable && follow_err > thr_q;

    // ==========================================================
    // Fault latches, power, relay and brake
    reg cnt_flt_q;
    reg frq_flt_q;
    reg ref_flt_q;
    reg fol_flt_q;
    wire latched = cnt_flt_q | frq_flt_q | ref_flt_q | fol_flt_q;
    wire sets = cnt_set | frq_set | ref_set | fol_set;
    wire fault_now = latched | sets | ext_fault | undervolt;
    wire uv_relay = undervolt && ctrl_q[`CTRL_UV_RELAY];

    always @(posedge CLK) begin
        if (SYS_RST) begin
            cnt_flt_q <= 1'b0;
            frq_flt_q <= 1'b0;
            ref_flt_q <= 1'b0;
            fol_flt_q <= 1'b0;
            PWR_EN <= 1'b0;
            DRIVE_OK_RELAY <= 1'b0;
            BRAKE_OUT <= 1'b0;
        end else begin
            // New detections win over a reset in the same cycle
            cnt_flt_q <= cnt_set | (cnt_flt_q & ~clr_req);
            frq_flt_q <= frq_set | (frq_flt_q & ~clr_req);
            ref_flt_q <= ref_set | (ref_flt_q & ~clr_req);
            fol_flt_q <= fol_set | (fol_flt_q & ~clr_req);
            PWR_EN <= enable && !fault_now;
            DRIVE_OK_RELAY <= !(latched | sets | ext_fault | uv_relay);
            BRAKE_OUT <= enable && !fault_now;
        end
    end

    // ==========================================================
    // Current reference
    wire [23:0] cmd_mag24 = mag24({{8{TORQUE_CMD[15]}}, TORQUE_CMD});
    wire [15:0] cmd_mag = cmd_mag24[15:0];
    wire [14:0] max15 = {maxc_q, 7'h00};
    wire [14:0] rated15 = {rated_q, 7'h00};
    wire [11:0] ana = ctrl_q[`CTRL_ILIM_REV] ? ILIM_ADC : ~ILIM_ADC;
    wire [26:0] ana_prod = {12'h000, max15} * {15'h0000, ana};
    wire [14:0] ana_lim = ana_prod[26:12];
    wire clamp;
    wire fb_cw = !SPEED_FB[15] && SPEED_FB != 16'h0000;
    wire fb_ccw = SPEED_FB[15];
    reg [14:0] lim;
    reg [15:0] sat;
    reg [15:0] cur_d;

    i2t_limit u_i2t (
        .clk(CLK),
        .rst(SYS_RST),
        .tick(ms_tick),
        .demand(cmd_mag),
        .rated(rated_q),
        .maxc(maxc_q),
        .clamp_q(clamp)
    );

    always @* begin
        lim = clamp ? rated15 : max15;
        if (ana_lim < lim) lim = ana_lim;
        sat = (cmd_mag > {1'b0, lim}) ? {1'b0, lim} : cmd_mag;
        cur_d = TORQUE_CMD[15] ? (~sat + 16'h0001) : sat;
        if (cw_limit_switch && fb_cw) cur_d = ~{1'b0, max15} + 16'h0001;
        else if (ccw_limit_switch && fb_ccw) cur_d = {1'b0, max15};
        else if (cw_limit_switch && !TORQUE_CMD[15]) cur_d = 16'h0000;
        else if (ccw_limit_switch && TORQUE_CMD[15]) cur_d = 16'h0000;
        if (torque_mode_select && zero_command_input) cur_d = 16'h0000;
        if (!PWR_EN) cur_d = 16'h0000;
    end

    // ==========================================================
    // Speed reference
    wire [23:0] spd_mag24 = mag24({{8{SPEED_REF[15]}}, SPEED_REF});
    reg [15:0] spd_d;
    always @* begin
        spd_d = SPEED_CMD;
        // The ramp holds its own value, so the command is ignored meanwhile
        if (!torque_mode_select && zero_command_input) begin
            spd_d = SPEED_REF;
            if (ms_tick) begin
                if (spd_mag24[15:0] <= ramp_q) spd_d = 16'h0000;
                else if (SPEED_REF[15]) spd_d = SPEED_REF + ramp_q;
                else spd_d = SPEED_REF - ramp_q;
            end
        end
        if (cw_limit_switch && !spd_d[15]) spd_d = 16'h0000;
        if (ccw_limit_switch && spd_d[15]) spd_d = 16'h0000;
        if (!PWR_EN) spd_d = 16'h0000;
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            CUR_REF <= 16'h0000;
            SPEED_REF <= 16'h0000;
        end else begin
            CUR_REF <= cur_d;
            SPEED_REF <= spd_d;
        end
    end

    // ==========================================================
    // Encoder emulation
    encoder_emulator u_emul (
        .clk(CLK),
        .rst(SYS_RST),
        .angle(SHAFT_ANGLE),
        .res(out_res_q),
        .div_sel(ctrl_q[`CTRL_DIV_HI:`CTRL_DIV_LO]),
        .max_speed(max_speed_q),
        .dband(dband_q),
        .zshift(zshift_q),
        .a_q(EMU_A),
        .b_q(EMU_B),
        .z_q(EMU_Z)
    );

    // ==========================================================
    // Read port
    always @(posedge CLK) begin
        if (SYS_RST || !RD_STB) begin
            RDATA <= 32'h0000_0000;
        end else begin
            case (ADDR)
                `ADDR_CTRL: RDATA <= {26'h0000000, ctrl_q};
                `ADDR_CURRENT: RDATA <= {16'h0000, maxc_q, rated_q};
                `ADDR_ENC: RDATA <= {12'h000, pitch_q, enc_res_q};
                `ADDR_MAX_SPEED: RDATA <= {16'h0000, max_speed_q};
                `ADDR_FOLLOW_THR: RDATA <= {8'h00, thr_q};
                `ADDR_OUT_RES: RDATA <= {17'h00000, out_res_q};
                `ADDR_DEADBAND: RDATA <= {20'h00000, dband_q};
                `ADDR_ZSHIFT: RDATA <= {17'h00000, zshift_q};
                `ADDR_RAMP: RDATA <= {16'h0000, ramp_q};
                `ADDR_STATUS: RDATA <= {22'h000000, BRAKE_OUT, ext_fault, undervolt,
                    DRIVE_OK_RELAY, PWR_EN, clamp, fol_flt_q, ref_flt_q, frq_flt_q, cnt_flt_q};
                `ADDR_POSITION: RDATA <= {8'h00, pos_q};
                `ADDR_EDGES: RDATA <= {16'h0000, edges_ms_q};
                default: RDATA <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* verification/enc_source.sv */
module enc_source (
    // Clock and pacing
    input wire clk,
    input wire run,
    input wire [7:0] z_every,
    // Encoder lines
    output logic enc_a,
    output logic enc_b,
    output logic enc_z
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q = 3'h0;
    logic [1:0] ph_q = 2'h0;
    logic [7:0] n_q = 8'h01;
    // One edge per 8 clocks stays under the rate limit at default speed
    always @(posedge clk) begin
        if (run) begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7) begin
                ph_q <= ph_q + 2'h1;
                n_q <= (n_q + 8'h01 == z_every) ? 8'h00 : n_q + 8'h01;
            end
        end
    end
    // A leads B, so the count runs up
    assign enc_a = ph_q[1] ^ ph_q[0];
    assign enc_b = ph_q[1];
    // Z rises on the edge that closes each span, never on a restart
    assign enc_z = n_q == 8'h00;
endmodule

/* verification/servo_drive_protection_io_monitor.sv */
module servo_drive_protection_io_monitor #(
    parameter MS_CYCLES = 125000
) (
    // Clock and pins
    input wire CLK,
    input wire SYS_RST,
    input wire CW_LIMIT_SWITCH,
    input wire CCW_LIMIT_SWITCH,
    input wire TORQUE_MODE_SELECT,
    input wire ZERO_COMMAND_INPUT,
    input wire ENABLE_IN,
    input wire EXT_FAULT_IN,
    // Drive outputs
    input wire [15:0] CUR_REF,
    input wire PWR_EN,
    input wire DRIVE_OK_RELAY,
    input wire BRAKE_OUT,
    input wire EMU_A,
    input wire EMU_B,
    input wire EMU_Z
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    // ==========
    // Pins pass a two-stage sync, so causes are held four cycles
    a_fault_power: assert property (EXT_FAULT_IN [*4] |=> !PWR_EN)
        else $error("power stage on during fault");
    a_fault_relay: assert property (EXT_FAULT_IN [*4] |=> !DRIVE_OK_RELAY)
        else $error("relay closed during fault");
    a_brake_fault: assert property (EXT_FAULT_IN [*4] |=> !BRAKE_OUT)
        else $error("brake driven during fault");
    a_enable_off: assert property (!ENABLE_IN [*4] |=> !PWR_EN && !BRAKE_OUT)
        else $error("drive on without enable");
    a_power_current: assert property (!PWR_EN [*3] |-> CUR_REF == 16'h0000)
        else $error("current with power stage off");
    a_torque_zero: assert property ((TORQUE_MODE_SELECT && ZERO_COMMAND_INPUT) [*4]
        |=> CUR_REF == 16'h0000) else $error("current under zero command");
    a_cw_block: assert property ((CW_LIMIT_SWITCH && !CCW_LIMIT_SWITCH) [*4]
        |=> $signed(CUR_REF) <= 0) else $error("cw current past limit");
    a_ccw_block: assert property ((CCW_LIMIT_SWITCH && !CW_LIMIT_SWITCH) [*4]
        |=> $signed(CUR_REF) >= 0) else $error("ccw current past limit");
    a_quad_step: assert property (!($changed(EMU_A) && $changed(EMU_B)))
        else $error("both channels moved at once");
    cover property (BRAKE_OUT);
    cover property (EXT_FAULT_IN [*4] ##1 !PWR_EN);
    cover property ($rose(EMU_Z));
endmodule

bind servo_drive_protection_io servo_drive_protection_io_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
    .CLK, .SYS_RST, .CW_LIMIT_SWITCH, .CCW_LIMIT_SWITCH, .TORQUE_MODE_SELECT,
    .ZERO_COMMAND_INPUT, .ENABLE_IN, .EXT_FAULT_IN, .CUR_REF, .PWR_EN, .DRIVE_OK_RELAY,
    .BRAKE_OUT, .EMU_A, .EMU_B, .EMU_Z
);

/* verification/tb_servo_drive_protection_io.sv */
module tb_servo_drive_protection_io;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 20;
    logic CLK = 1'b0, SYS_RST = 1'b1, WR_STB = 1'b0, RD_STB = 1'b0, run = 1'b0;
    logic [7:0] ADDR = 8'h00, zn = 8'h40;
    logic [31:0] WDATA = 32'h0, d;
    logic CW_LIMIT_SWITCH = 1'b0, CCW_LIMIT_SWITCH = 1'b0, TORQUE_MODE_SELECT = 1'b0;
    logic ZERO_COMMAND_INPUT = 1'b0, ENABLE_IN = 1'b0, UNDERVOLT_IN = 1'b0, EXT_FAULT_IN = 1'b0;
    logic [15:0] TORQUE_CMD = 16'h0, SPEED_CMD = 16'h0, SPEED_FB = 16'h0, SHAFT_ANGLE = 16'h0;
    logic [23:0] POS_ERR = 24'h0, MODEL_ERR = 24'h0;
    logic [11:0] ILIM_ADC = 12'h0;
    logic pa = 1'b0, pb = 1'b0, FAULT_RESET_IN = 1'b0;
    wire ENC_A, ENC_B, ENC_Z, PWR_EN, DRIVE_OK_RELAY, BRAKE_OUT, EMU_A, EMU_B, EMU_Z;
    wire [15:0] CUR_REF, SPEED_REF;
    wire [31:0] RDATA;
    int failures = 0, n_compared = 0, cycles = 0, ecount = 0, e0, i;
    logic [7:0] ra [9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h30};
    logic [31:0] rv [9] = '{32'h2010, 32'h10400, 32'hbb8, 32'h1000, 32'h400, 32'h0, 32'h0,
        32'h10, 32'h0};
    logic [23:0] fp [4] = '{24'h1000, 24'h1001, 24'h1800, 24'h1800};
    logic [23:0] fm [4] = '{24'h0, 24'h0, 24'h800, 24'h7ff};
    logic [14:0] er [6] = '{15'h200, 15'h200, 15'h200, 15'h200, 15'h100, 15'h4000};
    int ex [6] = '{32, 16, 8, 4, 32, 512};

    always #4 CLK = ~CLK;

    servo_drive_protection_io #(.MS_CYCLES(MS)) dut (
        .CLK, .SYS_RST, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA, .CW_LIMIT_SWITCH,
        .CCW_LIMIT_SWITCH, .TORQUE_MODE_SELECT, .ZERO_COMMAND_INPUT, .ENABLE_IN,
        .FAULT_RESET_IN, .UNDERVOLT_IN, .EXT_FAULT_IN, .ENC_A, .ENC_B, .ENC_Z,
        .TORQUE_CMD, .SPEED_CMD, .SPEED_FB, .POS_ERR, .MODEL_ERR, .ILIM_ADC, .SHAFT_ANGLE,
        .CUR_REF, .SPEED_REF, .PWR_EN, .DRIVE_OK_RELAY, .BRAKE_OUT, .EMU_A, .EMU_B, .EMU_Z
    );
    enc_source src (.clk(CLK), .run(run), .z_every(zn), .enc_a(ENC_A), .enc_b(ENC_B),
        .enc_z(ENC_Z));

    // ==========
    // Emulated edge count and hang guard
    always @(posedge CLK) begin
        pa <= EMU_A;
        pb <= EMU_B;
        if (EMU_A !== pa || EMU_B !== pb) ecount <= ecount + 1;
        cycles = cycles + 1;
        if (cycles == 60000) begin
            failures = failures + 1;
            results();
        end
    end

    // ==========
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ADDR <= a;
        WDATA <= v;
        WR_STB <= 1'b1;
        cyc(1);
        WR_STB <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a);
        ADDR <= a;
        RD_STB <= 1'b1;
        cyc(1);
        d = RDATA;
        RD_STB <= 1'b0;
        cyc(1);
    endtask
    task results;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ==========
    // Sequence
    initial begin
        cyc(4);
        SYS_RST <= 1'b0;
        cyc(1);
        for (i = 0; i < 9; i++) begin
            rd(ra[i]);
            chk(d, rv[i]);
        end
        ENABLE_IN <= 1'b1;
        TORQUE_MODE_SELECT <= 1'b1;
        TORQUE_CMD <= 16'h0100;
        cyc(6);
        chk({PWR_EN, DRIVE_OK_RELAY, BRAKE_OUT, CUR_REF}, {3'h7, 16'h0100});
        ZERO_COMMAND_INPUT <= 1'b1;
        cyc(6);
        chk(CUR_REF, 32'h0);
        ZERO_COMMAND_INPUT <= 1'b0;
        wr(8'h00, 32'h4);
        cyc(3);
        chk(CUR_REF, 32'h0);
        ILIM_ADC <= 12'hfff;
        cyc(3);
        chk(CUR_REF, 32'h0100);
        wr(8'h00, 32'h0);
        ILIM_ADC <= 12'h000;
        for (i = 0; i < 2; i++) begin
            CW_LIMIT_SWITCH <= (i == 0);
            CCW_LIMIT_SWITCH <= (i == 1);
            TORQUE_CMD <= i ? 16'hff00 : 16'h0100;
            cyc(6);
            chk(CUR_REF, 32'h0);
            SPEED_FB <= i ? 16'hff00 : 16'h0100;
            cyc(4);
            chk(i ? $signed(CUR_REF) > 2048 : $signed(CUR_REF) < -2048, 32'h1);
            SPEED_FB <= 16'h0;
        end
        CCW_LIMIT_SWITCH <= 1'b0;
        TORQUE_CMD <= 16'h0100;
        EXT_FAULT_IN <= 1'b1;
        cyc(5);
        chk({PWR_EN, DRIVE_OK_RELAY, BRAKE_OUT, CUR_REF}, 32'h0);
        EXT_FAULT_IN <= 1'b0;
        cyc(5);
        chk(PWR_EN, 32'h1);
        for (i = 0; i < 2; i++) begin
            wr(8'h00, i << 1);
            UNDERVOLT_IN <= 1'b1;
            cyc(5);
            chk({PWR_EN, DRIVE_OK_RELAY}, {1'b0, i == 0});
            UNDERVOLT_IN <= 1'b0;
            cyc(5);
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h00, i >> 1);
            POS_ERR <= fp[i];
            MODEL_ERR <= fm[i];
            cyc(6);
            chk(PWR_EN, !i[0]);
            POS_ERR <= 24'h0;
            MODEL_ERR <= 24'h0;
            cyc(4);
            rd(8'h24);
            chk({d[3], PWR_EN}, {i[0], !i[0]});
            wr(8'h00, 32'h8);
            cyc(4);
            chk(PWR_EN, 32'h1);
        end
        for (i = 0; i < 6; i++) begin
            wr(8'h14, er[i]);
            wr(8'h00, (i < 4 ? i : 0) << 4);
            cyc(3000);
            e0 = ecount;
            SHAFT_ANGLE <= SHAFT_ANGLE + 16'h0400;
            cyc(600);
            chk(ecount - e0, ex[i]);
        end
        wr(8'h1c, 32'hc00);
        chk(EMU_Z, 32'h1);
        wr(8'h1c, 32'hc01);
        chk(EMU_Z, 32'h0);
        wr(8'h18, 32'h100);
        e0 = ecount;
        SHAFT_ANGLE <= SHAFT_ANGLE + 16'h0080;
        cyc(100);
        chk(ecount - e0, 32'h0);
        wr(8'h08, 32'h10010);
        run <= 1'b1;
        cyc(1700);
        chk(PWR_EN, 32'h1);
        zn <= 8'd63;
        cyc(1100);
        rd(8'h24);
        chk({d[0], PWR_EN}, 32'h2);
        run <= 1'b0;
        cyc(20);
        chk(PWR_EN, 32'h0);
        FAULT_RESET_IN <= 1'b1;
        cyc(4);
        chk(PWR_EN, 32'h1);
        FAULT_RESET_IN <= 1'b0;
        wr(8'h0c, 32'h64);
        run <= 1'b1;
        cyc(80);
        rd(8'h24);
        chk({d[1], PWR_EN}, 32'h2);
        run <= 1'b0;
        wr(8'h0c, 32'hbb8);
        wr(8'h00, 32'h8);
        TORQUE_MODE_SELECT <= 1'b0;
        SPEED_CMD <= 16'h0100;
        cyc(6);
        chk(SPEED_REF, 32'h0100);
        ZERO_COMMAND_INPUT <= 1'b1;
        cyc(45);
        chk(SPEED_REF < 16'h0100 && SPEED_REF >= 16'h00d0, 32'h1);
        cyc(400);
        chk(SPEED_REF, 32'h0);
        ZERO_COMMAND_INPUT <= 1'b0;
        wr(8'h04, 32'h4010);
        rd(8'h04);
        chk(d, 32'h4010);
        TORQUE_MODE_SELECT <= 1'b1;
        TORQUE_CMD <= 16'h0c00;
        cyc(245 * MS);
        chk(CUR_REF, 32'h0c00);
        cyc(12 * MS);
        rd(8'h24);
        chk({d[5:4], CUR_REF}, {2'h3, 16'h0800});
        results();
    end
endmodule
